// ===== design/actc_top.sv
`default_nettype none
// Contract
// - Basic clock is CPU clock divided by 4, 2, 16 or 8 per select code.
// - Sample phase lasts 8, 16, 32 or 64 basic clock periods per code.
// - Conversion lasts exactly sample time, 40 basic periods and 2 CPU cycles.
// - Sample, resolve and load result within that time; load is last.
// - After reset a calibration of 3328 basic clock periods runs.
// - Conversions during calibration are accepted and lengthen calibration.
// - Input below ground gives all zeros, above reference gives 3FF.
// - Sampled input is held once the sample phase ends.
module actc_top #(
    parameter int CAL_BC = actc_pkg::CAL_BC_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Converter control register, bits 15..12 used
    input wire logic [15:0] converter_control_register,
    input wire logic start,
    // Analog front end, clocked by clk
    input wire actc_pkg::actc_analog_t ain,
    // Status and result
    output logic [actc_pkg::RES_W-1:0] result_r,
    output logic done_r,
    output logic busy_r,
    output logic cal_busy_r
);

    ////////////////////////////////////////////////////////////////////////
    localparam int RES_W_L = actc_pkg::RES_W;
    actc_pkg::actc_state_t state_r;
    actc_pkg::actc_timing_t tim_live;
    actc_pkg::actc_timing_t tim_r;
    actc_pkg::actc_analog_t hold_r;
    logic [4:0] div_sel;
    logic [3:0] presc_r;
    logic bc_tick;
    logic [6:0] bc_cnt_r;
    logic [6:0] smp_len;
    logic [RES_W_L-1:0] sar_r;
    logic [RES_W_L-1:0] mask_r;
    logic [RES_W_L-1:0] trial;
    logic [15:0] cal_cnt_r;
    logic [11:0] cyc_r;
    logic [11:0] smp_cyc;
    logic [11:0] tot_cyc;
    logic [4:0] gap_r;
    logic take;
    logic [4:0] div_conv;

    assign tim_live.conversion_clock_select =
        converter_control_register[actc_pkg::CCS_LSB +: actc_pkg::SEL_W];
    assign tim_live.sample_time_select =
        converter_control_register[actc_pkg::STS_LSB +: actc_pkg::SEL_W];
    // Idle periods use live settings so calibration follows software
    assign div_sel = (state_r == actc_pkg::ST_IDLE)
        ? actc_pkg::div_of(tim_live.conversion_clock_select)
        : actc_pkg::div_of(tim_r.conversion_clock_select);
    assign smp_len = actc_pkg::smp_of(tim_r.sample_time_select);
    assign bc_tick = ({1'b0, presc_r} == div_sel - 5'h01);
    assign take = ce && start && (state_r == actc_pkg::ST_IDLE);
    assign trial = sar_r | mask_r;

    ////////////////////////////////////////////////////////////////////////
    // Basic clock prescaler, restarted per conversion for a fixed length
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_r <= 4'h0;
        end else if (ce) begin
            if (take || bc_tick) begin
                presc_r <= 4'h0;
            end else begin
                presc_r <= presc_r + 4'h1;
            end
        end
    end

    // Settings are frozen for the whole conversion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tim_r <= '0;
        end else if (take) begin
            tim_r <= tim_live;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= actc_pkg::ST_IDLE;
            bc_cnt_r <= 7'h00;
        end else if (ce) begin
            case (state_r)
                actc_pkg::ST_IDLE: begin
                    bc_cnt_r <= 7'h00;
                    if (start) begin
                        state_r <= actc_pkg::ST_SAMPLE;
                    end
                end
                actc_pkg::ST_SAMPLE: begin
                    if (bc_tick) begin
                        if (bc_cnt_r == smp_len - 7'h01) begin
                            bc_cnt_r <= 7'h00;
                            state_r <= actc_pkg::ST_CONV;
                        end else begin
                            bc_cnt_r <= bc_cnt_r + 7'h01;
                        end
                    end
                end
                actc_pkg::ST_CONV: begin
                    if (bc_tick) begin
                        if (bc_cnt_r == actc_pkg::CONV_STEPS - 7'h01) begin
                            bc_cnt_r <= 7'h00;
                            state_r <= actc_pkg::ST_LOAD1;
                        end else begin
                            bc_cnt_r <= bc_cnt_r + 7'h01;
                        end
                    end
                end
                actc_pkg::ST_LOAD1: state_r <= actc_pkg::ST_LOAD2;
                actc_pkg::ST_LOAD2: state_r <= actc_pkg::ST_IDLE;
                default: state_r <= actc_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Track-and-hold: follows the input while sampling, frozen after
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_r <= '0;
        end else if (ce && (take || state_r == actc_pkg::ST_SAMPLE)) begin
            hold_r <= ain;
        end
    end

    // Successive approximation, one bit every four basic periods
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sar_r <= actc_pkg::RES_ZERO;
            mask_r <= actc_pkg::RES_ZERO;
        end else if (ce) begin
            if (state_r == actc_pkg::ST_SAMPLE) begin
                sar_r <= actc_pkg::RES_ZERO;
                mask_r <= actc_pkg::SAR_MSB;
            end else if (state_r == actc_pkg::ST_CONV && bc_tick &&
                         bc_cnt_r[1:0] == 2'(actc_pkg::BITS_PER_STEP - 1)) begin
                if (hold_r.level >= trial) begin
                    sar_r <= trial;
                end
                mask_r <= mask_r >> 1;
            end
        end
    end

    // Result load is the final step; out-of-range inputs clamp
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_r <= actc_pkg::RES_ZERO;
            done_r <= 1'b0;
        end else if (ce) begin
            done_r <= (state_r == actc_pkg::ST_LOAD2);
            if (state_r == actc_pkg::ST_LOAD2) begin
                if (hold_r.below) begin
                    result_r <= actc_pkg::RES_ZERO;
                end else if (hold_r.above) begin
                    result_r <= actc_pkg::RES_FULL;
                end else begin
                    result_r <= sar_r;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
        end else if (ce) begin
            busy_r <= take || (state_r != actc_pkg::ST_IDLE &&
                               state_r != actc_pkg::ST_LOAD2);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Calibration counts idle basic periods only, so conversions extend it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_busy_r <= 1'b1;
            cal_cnt_r <= 16'h0000;
        end else if (ce && cal_busy_r && state_r == actc_pkg::ST_IDLE &&
                     !start && bc_tick) begin
            cal_cnt_r <= cal_cnt_r + 16'h0001;
            if (cal_cnt_r == 16'(CAL_BC - 1)) begin
                cal_busy_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Helper counters for the checks below
    // Divisor of the running conversion; in the done cycle the sequencer is
    // idle and the live word may already hold other settings
    assign div_conv = actc_pkg::div_of(tim_r.conversion_clock_select);
    assign smp_cyc = 12'(smp_len * div_conv);
    assign tot_cyc = 12'((smp_len + actc_pkg::CONV_STEPS) * div_conv)
        + actc_pkg::LOAD_CYC;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_r <= 12'h000;
            gap_r <= 5'h00;
        end else if (ce) begin
            if (take) begin
                cyc_r <= 12'h000;
            end else if (state_r != actc_pkg::ST_IDLE) begin
                cyc_r <= cyc_r + 12'h001;
            end
            gap_r <= (take || bc_tick) ? 5'h01 : gap_r + 5'h01;
        end
    end

    a_bc_divide: assert property (@(posedge clk) disable iff (!rst_n)
        ce && bc_tick && state_r == actc_pkg::ST_CONV |-> gap_r == div_sel)
        else $error("basic clock period wrong");
    a_sample_len: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == actc_pkg::ST_CONV && $past(state_r) == actc_pkg::ST_SAMPLE
        |-> cyc_r == smp_cyc)
        else $error("sample phase length wrong");
    a_conv_total: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(done_r) |-> cyc_r == tot_cyc)
        else $error("conversion length wrong");
    a_result_last: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(result_r) |-> done_r && !busy_r)
        else $error("result written outside final step");
    a_cal_end: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(cal_busy_r) |-> cal_cnt_r == 16'(CAL_BC))
        else $error("calibration length wrong");
    a_cal_pause: assert property (@(posedge clk) disable iff (!rst_n)
        state_r != actc_pkg::ST_IDLE ##1 state_r != actc_pkg::ST_IDLE
        |-> $stable(cal_cnt_r) && $stable(cal_busy_r))
        else $error("calibration advanced during conversion");
    a_clamp_low: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(done_r) && hold_r.below |-> result_r == actc_pkg::RES_ZERO)
        else $error("low clamp missing");
    a_clamp_high: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(done_r) && !hold_r.below && hold_r.above
        |-> result_r == actc_pkg::RES_FULL)
        else $error("high clamp missing");
    a_hold_frozen: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == actc_pkg::ST_CONV |=> $stable(hold_r))
        else $error("held sample changed");
    a_start_taken: assert property (@(posedge clk) disable iff (!rst_n)
        take |=> busy_r && state_r == actc_pkg::ST_SAMPLE)
        else $error("start request not taken");
    a_settings_kept: assert property (@(posedge clk) disable iff (!rst_n)
        busy_r && !take |=> $stable(tim_r))
        else $error("timing settings changed mid conversion");

    c_conv_done: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(done_r));
    c_conv_in_cal: cover property (@(posedge clk) disable iff (!rst_n)
        take && cal_busy_r);
    c_cal_done: cover property (@(posedge clk) disable iff (!rst_n)
        $fell(cal_busy_r));
    c_clamped: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(done_r) && result_r == actc_pkg::RES_FULL);

endmodule // actc_top
`default_nettype wire

// ===== shared/actc_pkg.sv
`default_nettype none
package actc_pkg;
    // Control register field positions
    localparam int CCS_LSB = 14;
    localparam int STS_LSB = 12;
    localparam int SEL_W = 2;
    // Converter timing
    localparam int RES_W = 10;
    localparam logic [6:0] CONV_STEPS = 7'h28;
    localparam logic [11:0] LOAD_CYC = 12'h002;
    localparam int CAL_BC_DEF = 3328;
    localparam int BITS_PER_STEP = 4;
    localparam logic [RES_W-1:0] RES_ZERO = 10'h000;
    localparam logic [RES_W-1:0] RES_FULL = 10'h3FF;
    localparam logic [RES_W-1:0] SAR_MSB = 10'h200;
    localparam int CLK_PERIOD_NS = 100;
    // Basic clock divisors per select code
    localparam logic [4:0] DIV_C0 = 5'h04;
    localparam logic [4:0] DIV_C1 = 5'h02;
    localparam logic [4:0] DIV_C2 = 5'h10;
    localparam logic [4:0] DIV_C3 = 5'h08;
    // Sample length in basic clock periods per select code
    localparam logic [6:0] SMP_C0 = 7'h08;
    localparam logic [6:0] SMP_C1 = 7'h10;
    localparam logic [6:0] SMP_C2 = 7'h20;
    localparam logic [6:0] SMP_C3 = 7'h40;

    typedef struct packed {
        logic [SEL_W-1:0] conversion_clock_select;
        logic [SEL_W-1:0] sample_time_select;
    } actc_timing_t;

    typedef struct packed {
        logic below;
        logic above;
        logic [RES_W-1:0] level;
    } actc_analog_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SAMPLE = 5'b00010,
        ST_CONV = 5'b00100,
        ST_LOAD1 = 5'b01000,
        ST_LOAD2 = 5'b10000
    } actc_state_t;

    function automatic logic [4:0] div_of(input logic [SEL_W-1:0] sel);
        case (sel)
            2'h0: div_of = DIV_C0;
            2'h1: div_of = DIV_C1;
            2'h2: div_of = DIV_C2;
            default: div_of = DIV_C3;
        endcase
    endfunction

    function automatic logic [6:0] smp_of(input logic [SEL_W-1:0] sel);
        case (sel)
            2'h0: smp_of = SMP_C0;
            2'h1: smp_of = SMP_C1;
            2'h2: smp_of = SMP_C2;
            default: smp_of = SMP_C3;
        endcase
    endfunction
endpackage
`default_nettype wire

// ===== tb/actc_ain_model.sv
`default_nettype none
module actc_ain_model (
    // Clock
    input wire logic clk,
    // Source settings
    input wire logic [9:0] lvl,
    input wire logic below,
    input wire logic above,
    input wire logic scramble,
    // Front end
    output var actc_pkg::actc_analog_t ain
);
    timeunit 1ns;
    timeprecision 1ns;
    initial ain = '0;
    // Past the hold point the input keeps moving, so a sampler that still
    // tracks shows up as a wrong result
    always @(posedge clk) begin
        ain.below <= below;
        ain.above <= above;
        ain.level <= scramble ? ~ain.level : lvl;
    end
endmodule // actc_ain_model
`default_nettype wire

// ===== tb/adc_conversion_timing_control_bench.sv
`default_nettype none
module adc_conversion_timing_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CAL = 20;
    logic clk, rst_n, ce, start, below, above, scramble;
    logic [15:0] ctl;
    logic [9:0] lvl;
    actc_pkg::actc_analog_t ain;
    logic [9:0] result_r;
    logic done_r, busy_r, cal_busy_r;
    int errors, cmp_count;

    actc_ain_model u_ain (.clk(clk), .lvl(lvl), .below(below),
        .above(above), .scramble(scramble), .ain(ain));
    actc_top #(.CAL_BC(CAL)) u_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .converter_control_register(ctl), .start(start), .ain(ain),
        .result_r(result_r), .done_r(done_r), .busy_r(busy_r),
        .cal_busy_r(cal_busy_r));

    ////////////////////////////////////////////////////////////////////////
    function automatic int div_f(input logic [1:0] c);
        return c == 2'h0 ? 4 : c == 2'h1 ? 2 : c == 2'h2 ? 16 : 8;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        ctl <= 16'h0000;
        repeat (16) @(posedge clk);
        #1 chk({13'h0, cal_busy_r, busy_r, done_r}, 16'h0004);
        chk({6'h0, result_r}, 16'h0000);
        @(posedge clk);
        rst_n <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // pre: start already raised in the previous done cycle
    task automatic run_conv(input logic [3:0] code, input logic [9:0] v,
        input logic bl, input logic ab, input logic pre, input logic b2b,
        input logic frz, input logic [9:0] exp_res);
        int n, len, smp;
        smp = (8 << code[1:0]) * div_f(code[3:2]);
        len = smp + 40 * div_f(code[3:2]) + 2 + (frz ? 5 : 0);
        n = 0;
        if (!pre) begin
            @(posedge clk);
            ctl <= {code, 12'h000};
            start <= 1'b1;
        end
        @(posedge clk);
        start <= 1'b0;
        lvl <= v;
        below <= bl;
        above <= ab;
        scramble <= 1'b0;
        #1 chk({15'h0, busy_r}, 16'h0001);
        while (n < 3000) begin
            @(posedge clk);
            if (n == 4) ctl <= {~code, 12'h000};
            // Input starts moving right after the last tracking edge
            if (n == smp + (frz ? 3 : -2)) scramble <= 1'b1;
            ce <= !(frz && n >= 10 && n < 15);
            if (b2b && n == len - 1) start <= 1'b1;
            #1 n++;
            if (done_r === 1'b1) break;
        end
        chk(16'(n), 16'(len));
        chk({6'h0, result_r}, {6'h0, exp_res});
        chk({15'h0, busy_r}, 16'h0000);
    endtask

    task automatic cal_wait(input int lo, input int hi);
        int n;
        n = 0;
        while (cal_busy_r === 1'b1 && n < 2000) begin
            @(posedge clk);
            #1 n++;
        end
        chk({15'h0, n >= lo && n <= hi}, 16'h0001);
    endtask

    task automatic t_cal_plain();
        do_reset();
        cal_wait(CAL * 4 - 4, CAL * 4 + 4);
    endtask

    // Code F leaves the live word at 0 afterwards, so the rest runs at /4
    task automatic t_cal_conv();
        do_reset();
        repeat (10) @(posedge clk);
        run_conv(4'hF, 10'h155, 0, 0, 0, 0, 0, 10'h155);
        chk({15'h0, cal_busy_r}, 16'h0001);
        cal_wait(CAL * 4 - 17, CAL * 4 - 5);
    endtask

    task automatic t_codes();
        for (int c = 0; c < 16; c++) begin
            run_conv(4'(c), 10'(c * 61), 0, 0, 0, 0, 0, 10'(c * 61));
        end
    endtask

    task automatic t_b2b_freeze();
        run_conv(4'hA, 10'h3FE, 0, 0, 0, 1, 1, 10'h3FE);
        run_conv(4'h5, 10'h001, 0, 0, 1, 0, 0, 10'h001);
    endtask

    task automatic t_clamp();
        run_conv(4'h1, 10'h155, 1, 0, 0, 0, 0, 10'h000);
        run_conv(4'h1, 10'h155, 0, 1, 0, 0, 0, 10'h3FF);
        run_conv(4'h1, 10'h155, 1, 1, 0, 0, 0, 10'h000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Whole run is about 12000 cycles; five times that means a hang
    initial begin
        #(60000 * 100);
        errors++;
        give_verdict();
    end

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        start = 1'b0;
        ctl = 16'h0000;
        lvl = 10'h000;
        below = 1'b0;
        above = 1'b0;
        scramble = 1'b0;
        errors = 0;
        cmp_count = 0;
        t_cal_plain();
        t_cal_conv();
        t_codes();
        t_b2b_freeze();
        t_clamp();
        give_verdict();
    end
endmodule // adc_conversion_timing_control_bench
`default_nettype wire
